// *** hw/pwfu_core.sv ***
// Page walk and fault unit: second-level decode, domain and permission
// checks, fault ranking, fault status and fault address registers.
// Assumes one core clock; all inputs come from logic on that clock.
`timescale 1ns/10ps
`include "pwfu_params.svh"

// Contract
// - Entry bits 1:0: 00 invalid faults, 01 large 64 kB, 10 small 4 kB.
// - Entry bit 2 is bufferable, bit 3 is cacheable.
// - Entry bits 11:4 hold four sub-page permission fields.
// - Page number is bits 31:12 small or 31:16 large.
// - Section permissions are checked before any physical address.
// - Page table descriptor fetches the entry; entry checked before address.
// - Alignment, translation, domain or permission faults abort the access.
// - Violations are found before and suppress the external cycle.
// - Fast bus may show the aborted address but never runs a cycle.
// - Data abort writes code and domain to status, address to register.
// - Prefetch abort only tags the instruction for execution.
// - Prefetch aborts leave status and address registers unchanged.
// - Coinciding aborts report only the highest priority source.
// - Alignment code is 00x1, domain field undefined.
// - Translation 0101/0111, domain 1001/1011 for section/page.
// - Permission 1101/1111, line-fetch bus error 0100/0110.
// - Other bus error 1000/1010; section translation keeps bits 8:5.
// - Sixteen two-bit domains in one 32-bit register.
// - Domain 00 or 10 gives a domain fault.
// - Domain 01 checks descriptor permission bits.
// - Domain 11 skips the permission check.
// - Level-one bit 1 picks section versus page table.
// - Top quarter uses top field; quarters 1 kB small, 16 kB large.
module pwfu_core
	import pwfu_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic mmu_en,
	input wire logic align_en,
	input wire logic fastbus,
	input wire logic perm_s,
	input wire logic perm_r,
	input wire logic req_valid,
	input pwfu_req_t req,
	output logic req_ready_q,
	output pwfu_rsp_t rsp_q,
	output logic walk_req_q,
	output logic [31:0] walk_addr_q,
	input wire logic walk_ack,
	input wire logic walk_err,
	input wire logic [31:0] walk_rdata,
	output logic mem_start_q,
	output logic [31:0] ext_addr_q,
	input wire logic mem_done,
	input wire logic mem_err,
	input wire logic mem_linefetch,
	input wire logic cp_wr,
	input wire logic cp_rd,
	input wire logic [3:0] cp_reg,
	input wire logic [31:0] cp_wdata,
	output logic [31:0] cp_rdata_q,
	output logic tlb_flush_q,
	output logic tlb_purge_q,
	output logic [31:0] purge_addr_q
);

	// -------------------------------------------------------------------
	// State
	// -------------------------------------------------------------------
	pwfu_state_t state_q;
	pwfu_state_t state_d;
	pwfu_req_t req_q;
	logic [31:0] l2_q;
	logic is_page_q;
	logic [31:0] domain_access_control_q;
	logic [31:0] fault_status_q;
	logic [31:0] fault_address_q;
	logic walk_err_q;
	logic fault_seen_q;

	// Permission table for one two-bit field, with the S and R bits.
	function automatic logic perm_ok(input logic [1:0] ap, input logic s,
		input logic r, input logic user, input logic wr);
		logic ok;
		ok = 1'b0;
		case (ap)
			2'h0: begin
				if (s && r) begin
					ok = 1'b0;
				end else if (s) begin
					ok = !user && !wr;
				end else if (r) begin
					ok = !wr;
				end else begin
					ok = 1'b0;
				end
			end
			2'h1: ok = !user && !(s && r);
			2'h2: ok = (!user || !wr) && !(s && r);
			default: ok = !(s && r);
		endcase
		return ok;
	endfunction

	// -------------------------------------------------------------------
	// Descriptor decode
	// -------------------------------------------------------------------
	// Level-one type: bit 1 alone separates section from page table.
	wire logic [31:0] l1 = req_q.l1_desc;
	wire logic l1_bad = (l1[1] == l1[0]);
	wire logic l1_section = l1[1];
	wire logic [3:0] dom_num = l1[8:5];
	wire logic [1:0] dom_bits = domain_access_control_q[{dom_num, 1'b0} +: 2];
	wire logic dom_fault = (dom_bits == `PWFU_DOM_NONE) ||
		(dom_bits == `PWFU_DOM_RSVD);
	wire logic dom_client = (dom_bits == `PWFU_DOM_CLIENT);

	// Second-level entry fields.
	wire logic [1:0] l2_type = l2_q[1:0];
	wire logic l2_large = (l2_type == `PWFU_L2_LARGE);
	wire logic l2_bad = (l2_type == `PWFU_L2_INVALID) ||
		(l2_type == `PWFU_L2_RSVD);
	wire logic [7:0] sub_fields = l2_q[11:4];
	// Sub-page index: quarter of a 4 kB or 64 kB page.
	wire logic [1:0] sub_idx = l2_large ? req_q.va[15:14] :
		req_q.va[11:10];
	wire logic [1:0] sub_ap = sub_fields[{sub_idx, 1'b0} +: 2];
	wire logic [1:0] sec_ap = l1[11:10];

	// Permission checks, only invoked for client domains.
	wire logic sec_perm_ok = perm_ok(sec_ap, perm_s, perm_r,
		req_q.is_user, req_q.is_write);
	wire logic page_perm_ok = perm_ok(sub_ap, perm_s, perm_r,
		req_q.is_user, req_q.is_write);

	// Physical addresses; bits 15:12 of a large entry are not used.
	wire logic [31:0] pa_small = {l2_q[31:12], req_q.va[11:0]};
	wire logic [31:0] pa_large = {l2_q[31:16], req_q.va[15:0]};
	wire logic [31:0] pa_page = l2_large ? pa_large : pa_small;
	wire logic [31:0] pa_sect = {l1[31:20], req_q.va[19:0]};
	wire logic [31:0] pa_out = !mmu_en ? req_q.va :
		(is_page_q ? pa_page : pa_sect);
	// Second-level entry address from the page table descriptor.
	wire logic [31:0] l2_addr = {l1[31:10], req_q.va[19:12], 2'h0};

	wire logic align_fault = align_en && req_q.is_data && req_q.is_word &&
		(req_q.va[1:0] != 2'h0);

	// -------------------------------------------------------------------
	// Fault ranking
	// -------------------------------------------------------------------
	// Each stage checks its sources from highest to lowest, so a later
	// source is only looked at when all earlier ones are clean.
	logic fault_hit;
	logic [3:0] fault_code;
	always_comb begin
		fault_hit = 1'b0;
		fault_code = 4'h0;
		case (state_q)
			PWFU_CHECK: begin
				fault_hit = 1'b1;
				if (align_fault) begin
					fault_code = `PWFU_FC_ALIGN;
				end else if (!mmu_en) begin
					fault_hit = 1'b0;
				end else if (req_q.l1_err) begin
					fault_code = `PWFU_FC_WALK_L1;
				end else if (l1_bad) begin
					fault_code = `PWFU_FC_TRANS_SEC;
				end else if (!l1_section) begin
					fault_hit = 1'b0;
				end else if (dom_fault) begin
					fault_code = `PWFU_FC_DOM_SEC;
				end else if (dom_client && !sec_perm_ok) begin
					fault_code = `PWFU_FC_PERM_SEC;
				end else begin
					fault_hit = 1'b0;
				end
			end
			PWFU_PCHK: begin
				fault_hit = 1'b1;
				if (walk_err_q) begin
					fault_code = `PWFU_FC_WALK_L2;
				end else if (l2_bad) begin
					fault_code = `PWFU_FC_TRANS_PAGE;
				end else if (dom_fault) begin
					fault_code = `PWFU_FC_DOM_PAGE;
				end else if (dom_client && !page_perm_ok) begin
					fault_code = `PWFU_FC_PERM_PAGE;
				end else begin
					fault_hit = 1'b0;
				end
			end
			PWFU_MEM: begin
				fault_hit = mem_done && mem_err;
				if (mem_linefetch) begin
					fault_code = is_page_q ? `PWFU_FC_LINE_PAGE :
						`PWFU_FC_LINE_SEC;
				end else begin
					fault_code = is_page_q ? `PWFU_FC_BUS_PAGE :
						`PWFU_FC_BUS_SEC;
				end
			end
			default: begin
				fault_hit = 1'b0;
				fault_code = 4'h0;
			end
		endcase
	end

	// Domain field: undefined for alignment, read as zero here; level-one
	// bits 8:5 for every other source, even a section translation fault.
	wire logic [3:0] fault_dom = (fault_code == `PWFU_FC_ALIGN) ? 4'h0 :
		dom_num;

	// -------------------------------------------------------------------
	// Next state
	// -------------------------------------------------------------------
	wire logic need_walk = mmu_en && !l1_section && !fault_hit;
	always_comb begin
		state_d = state_q;
		case (state_q)
			PWFU_IDLE: if (req_valid) state_d = PWFU_CHECK;
			PWFU_CHECK: begin
				if (fault_hit) begin
					state_d = PWFU_RESP;
				end else if (need_walk) begin
					state_d = PWFU_L2;
				end else begin
					state_d = PWFU_MEM;
				end
			end
			PWFU_L2: if (walk_ack) state_d = PWFU_PCHK;
			PWFU_PCHK: state_d = fault_hit ? PWFU_RESP : PWFU_MEM;
			PWFU_MEM: if (mem_done) state_d = PWFU_RESP;
			PWFU_RESP: state_d = PWFU_IDLE;
			default: state_d = PWFU_IDLE;
		endcase
	end

	// A fault found in CHECK or PCHK ends the access in that stage, so the
	// external cycle start below is never raised for it.
	wire logic to_mem = (state_d == PWFU_MEM) && (state_q != PWFU_MEM);
	wire logic stage_fault = fault_hit;
	wire logic data_fault = stage_fault && req_q.is_data;
	wire logic fault_seen_d = stage_fault || fault_seen_q;

	// -------------------------------------------------------------------
	// Walk and access sequencing
	// -------------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= PWFU_IDLE;
			req_q <= '0;
			l2_q <= 32'h00000000;
			is_page_q <= 1'b0;
			walk_err_q <= 1'b0;
			walk_req_q <= 1'b0;
			walk_addr_q <= 32'h00000000;
			fault_seen_q <= 1'b0;
		end else begin
			state_q <= state_d;
			if (state_q == PWFU_IDLE && req_valid) begin
				req_q <= req;
				is_page_q <= 1'b0;
				fault_seen_q <= 1'b0;
			end else if (state_q != PWFU_RESP) begin
				fault_seen_q <= fault_seen_d;
			end
			if (state_q == PWFU_CHECK && need_walk) begin
				walk_req_q <= 1'b1;
				walk_addr_q <= l2_addr;
				is_page_q <= 1'b1;
			end else if (walk_ack) begin
				walk_req_q <= 1'b0;
			end
			if (state_q == PWFU_L2 && walk_ack) begin
				l2_q <= walk_rdata;
				walk_err_q <= walk_err;
			end
		end
	end

	// -------------------------------------------------------------------
	// External bus and answer to the core
	// -------------------------------------------------------------------
	// In fast bus mode the aborted translation still reaches the address
	// pins, but the start strobe stays low so no cycle runs to it.
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			mem_start_q <= 1'b0;
			ext_addr_q <= 32'h00000000;
			rsp_q <= '0;
			req_ready_q <= 1'b0;
		end else begin
			mem_start_q <= to_mem;
			if (to_mem || (stage_fault && fastbus && state_q != PWFU_MEM)) begin
				ext_addr_q <= pa_out;
			end
			req_ready_q <= (state_d == PWFU_IDLE);
			rsp_q.valid <= (state_q == PWFU_RESP);
			rsp_q.abort <= (state_q == PWFU_RESP) && fault_seen_q;
			rsp_q.iabort_tag <= (state_q == PWFU_RESP) && fault_seen_q &&
				!req_q.is_data;
			if (state_q == PWFU_RESP) begin
				rsp_q.pa <= pa_out;
				rsp_q.bufferable <= mmu_en && (is_page_q ? l2_q[2] : l1[2]);
				rsp_q.cacheable <= mmu_en && (is_page_q ? l2_q[3] : l1[3]);
			end
		end
	end

	// -------------------------------------------------------------------
	// Coprocessor registers
	// -------------------------------------------------------------------
	// Status and address are written by data faults only; software writes
	// to those numbers flush or purge the translation cache instead.
	wire logic wr_dom = cp_wr && (cp_reg == `PWFU_REG_DOMAIN);
	wire logic wr_flush = cp_wr && (cp_reg == `PWFU_REG_STATUS);
	wire logic wr_purge = cp_wr && (cp_reg == `PWFU_REG_ADDR);
	wire logic [31:0] rd_mux = (cp_reg == `PWFU_REG_DOMAIN) ?
		domain_access_control_q :
		(cp_reg == `PWFU_REG_STATUS) ? fault_status_q :
		(cp_reg == `PWFU_REG_ADDR) ? fault_address_q : 32'h00000000;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			domain_access_control_q <= `PWFU_DAC_RST;
			fault_status_q <= `PWFU_FSR_RST;
			fault_address_q <= `PWFU_FAR_RST;
			cp_rdata_q <= 32'h00000000;
			tlb_flush_q <= 1'b0;
			tlb_purge_q <= 1'b0;
			purge_addr_q <= 32'h00000000;
		end else begin
			if (wr_dom) begin
				domain_access_control_q <= cp_wdata;
			end
			if (data_fault) begin
				fault_status_q <= {24'h000000, fault_dom, fault_code};
				fault_address_q <= req_q.va;
			end
			cp_rdata_q <= cp_rd ? rd_mux : 32'h00000000;
			tlb_flush_q <= wr_flush;
			tlb_purge_q <= wr_purge;
			if (wr_purge) begin
				purge_addr_q <= cp_wdata;
			end
		end
	end

endmodule

// *** hw/pwfu_params.svh ***
// Constants of the page walk and fault unit: register numbers, descriptor
// encodings, fault codes and reset values.
// Assumes inclusion by bare name from the design files.
`ifndef PWFU_PARAMS_SVH
`define PWFU_PARAMS_SVH

// -----------------------------------------------------------------------
// Coprocessor register numbers
// -----------------------------------------------------------------------
`define PWFU_REG_DOMAIN 4'h3
`define PWFU_REG_STATUS 4'h5
`define PWFU_REG_ADDR 4'h6

// -----------------------------------------------------------------------
// Reset values
// -----------------------------------------------------------------------
`define PWFU_DAC_RST 32'h00000000
`define PWFU_FSR_RST 32'h00000000
`define PWFU_FAR_RST 32'h00000000

// -----------------------------------------------------------------------
// Descriptor encodings
// -----------------------------------------------------------------------
`define PWFU_L2_INVALID 2'h0
`define PWFU_L2_LARGE 2'h1
`define PWFU_L2_SMALL 2'h2
`define PWFU_L2_RSVD 2'h3
`define PWFU_DOM_NONE 2'h0
`define PWFU_DOM_CLIENT 2'h1
`define PWFU_DOM_RSVD 2'h2
`define PWFU_DOM_MANAGER 2'h3

// -----------------------------------------------------------------------
// Fault codes
// -----------------------------------------------------------------------
`define PWFU_FC_ALIGN 4'h1
`define PWFU_FC_WALK_L1 4'hC
`define PWFU_FC_WALK_L2 4'hE
`define PWFU_FC_TRANS_SEC 4'h5
`define PWFU_FC_TRANS_PAGE 4'h7
`define PWFU_FC_DOM_SEC 4'h9
`define PWFU_FC_DOM_PAGE 4'hB
`define PWFU_FC_PERM_SEC 4'hD
`define PWFU_FC_PERM_PAGE 4'hF
`define PWFU_FC_LINE_SEC 4'h4
`define PWFU_FC_LINE_PAGE 4'h6
`define PWFU_FC_BUS_SEC 4'h8
`define PWFU_FC_BUS_PAGE 4'hA

`endif

// *** hw/pwfu_pkg.sv ***
// Types shared by the page walk and fault unit and its surroundings.
// Assumes nothing beyond a SystemVerilog compiler.
package pwfu_pkg;

	// Access presented by the core together with its level-one descriptor.
	typedef struct packed {
		logic [31:0] va;
		logic [31:0] l1_desc;
		logic l1_err;
		logic is_data;
		logic is_word;
		logic is_write;
		logic is_user;
	} pwfu_req_t;

	// Outcome of an access handed back to the core.
	typedef struct packed {
		logic valid;
		logic abort;
		logic iabort_tag;
		logic [31:0] pa;
		logic cacheable;
		logic bufferable;
	} pwfu_rsp_t;

	typedef enum logic [2:0] {
		PWFU_IDLE,
		PWFU_CHECK,
		PWFU_L2,
		PWFU_PCHK,
		PWFU_MEM,
		PWFU_RESP
	} pwfu_state_t;

endpackage

// *** sim/pwfu_mem_model.sv ***
// Far-side model: the page table memory and the external bus.
// Assumes the bench sets entry, latency and error flags between accesses.
`timescale 1ns/10ps
module pwfu_mem_model (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic walk_req_q,
	output logic walk_ack,
	output logic walk_err,
	output logic [31:0] walk_rdata,
	input wire logic mem_start_q,
	output logic mem_done,
	output logic mem_err,
	input wire logic [31:0] entry,
	input wire logic [1:0] lat,
	input wire logic walk_fail,
	input wire logic mem_fail
);
	logic [2:0] wcnt;
	logic [2:0] mcnt;
	// Every slot returns one entry, as sixteen copies of a large page would.
	// Between answers the data lines scramble, so stale data cannot pass.
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			{walk_ack, walk_err, mem_done, mem_err, wcnt, mcnt} <= '0;
			walk_rdata <= 32'h0;
		end else begin
			walk_ack <= 1'h0;
			walk_rdata <= ~walk_rdata;
			mem_done <= 1'h0;
			wcnt <= (walk_req_q && !walk_ack) ? wcnt + 3'h1 : 3'h0;
			if (walk_req_q && !walk_ack && wcnt == {1'h0, lat}) begin
				walk_ack <= 1'h1;
				walk_err <= walk_fail;
				walk_rdata <= entry;
			end
			mcnt <= (mcnt != 3'h0) ? mcnt - 3'h1 : 3'h0;
			if (mem_start_q) mcnt <= {1'h0, lat} + 3'h1;
			if (mcnt == 3'h1) begin
				mem_done <= 1'h1;
				mem_err <= mem_fail;
			end
		end
	end
endmodule

// *** sim/pwfu_properties.sv ***
// Port checker for the page walk and fault unit.
// Assumes binding to pwfu_core, with one clock and an active-low reset.
`timescale 1ns/10ps
`include "pwfu_params.svh"
module pwfu_properties
	import pwfu_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic align_en,
	input wire logic req_valid,
	input pwfu_req_t req,
	input wire logic req_ready_q,
	input pwfu_rsp_t rsp_q,
	input wire logic walk_req_q,
	input wire logic [31:0] walk_addr_q,
	input wire logic walk_ack,
	input wire logic mem_start_q,
	input wire logic cp_wr,
	input wire logic cp_rd,
	input wire logic [3:0] cp_reg,
	input wire logic [31:0] cp_wdata,
	input wire logic [31:0] cp_rdata_q
);
	// ---------------------------------------------------------------
	// Helper logic
	// ---------------------------------------------------------------
	default clocking dflt @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	logic [31:0] dac_q;
	// Only the three mapped numbers may return data.
	wire logic cp_hit = cp_reg == `PWFU_REG_DOMAIN
		|| cp_reg == `PWFU_REG_STATUS || cp_reg == `PWFU_REG_ADDR;
	// Mirror of the domain register, fed only by coprocessor writes.
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			dac_q <= `PWFU_DAC_RST;
		end else if (cp_wr && cp_reg == `PWFU_REG_DOMAIN) begin
			dac_q <= cp_wdata;
		end
	end
	sequence mis_take;
		req_valid && req_ready_q && align_en && req.is_data && req.is_word
			&& req.va[1:0] != 2'h0;
	endsequence
	sequence walk_done;
		walk_req_q && walk_ack;
	endsequence
	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	align_abort_a: assert property (mis_take |=>
		(!mem_start_q)[*3] ##0 (rsp_q.valid && rsp_q.abort))
		else $error("misaligned access not aborted in time");
	abort_valid_a: assert property (rsp_q.abort |-> rsp_q.valid)
		else $error("abort without answer");
	itag_abort_a: assert property (rsp_q.iabort_tag |-> rsp_q.abort)
		else $error("instruction tag without abort");
	walk_hold_a: assert property (walk_req_q && !walk_ack |=>
		walk_req_q && $stable(walk_addr_q))
		else $error("walk request dropped early");
	walk_check_a: assert property (walk_done |=>
		!walk_req_q && !mem_start_q)
		else $error("entry not checked before address");
	take_check_a: assert property (req_valid && req_ready_q |=>
		!req_ready_q && !mem_start_q)
		else $error("external cycle before check");
	cp_zero_a: assert property (!(cp_rd && cp_hit) |=>
		cp_rdata_q == 32'h0)
		else $error("read data outside a mapped read");
	dac_read_a: assert property (cp_rd && !cp_wr
		&& cp_reg == `PWFU_REG_DOMAIN |=> cp_rdata_q == dac_q)
		else $error("domain register read mismatch");
endmodule
bind pwfu_core pwfu_properties u_props (.core_clk(core_clk),
	.rst_b(rst_b), .align_en(align_en), .req_valid(req_valid), .req(req),
	.req_ready_q(req_ready_q), .rsp_q(rsp_q), .walk_req_q(walk_req_q),
	.walk_addr_q(walk_addr_q), .walk_ack(walk_ack),
	.mem_start_q(mem_start_q), .cp_wr(cp_wr), .cp_rd(cp_rd),
	.cp_reg(cp_reg), .cp_wdata(cp_wdata), .cp_rdata_q(cp_rdata_q));

// *** sim/test_page_walk_fault_unit.sv ***
// Self-checking bench for the page walk and fault unit.
// Assumes the memory model and the bound checker are compiled alongside.
`timescale 1ns/10ps
`include "pwfu_params.svh"
module test_page_walk_fault_unit import pwfu_pkg::*;;
	logic core_clk = 1'h0, rst_b = 1'h0, align_en = 1'h1, fastbus = 1'h0;
	logic req_valid = 1'h0, cp_wr = 1'h0, cp_rd = 1'h0;
	logic walk_fail = 1'h0, mem_fail = 1'h0, ab, tg, lf = 1'h0;
	logic [3:0] cp_reg = 4'h0;
	logic [31:0] cp_wdata = 32'h0, entry = 32'h0, rd, pa;
	logic [1:0] lat = 2'h0, cbits;
	pwfu_req_t req = '0;
	pwfu_rsp_t rsp_q;
	logic req_ready_q, walk_req_q, walk_ack, walk_err, mem_start_q;
	logic mem_done, mem_err, tlb_flush_q, tlb_purge_q;
	logic [31:0] walk_addr_q, walk_rdata, ext_addr_q, cp_rdata_q;
	logic [31:0] purge_addr_q;
	int num_errors = 0, n_compared = 0;

	always #5 core_clk = ~core_clk;
	pwfu_core dut (.core_clk, .rst_b, .mmu_en(1'h1), .align_en, .fastbus,
		.perm_s(1'h0), .perm_r(1'h0), .req_valid, .req, .req_ready_q, .rsp_q,
		.walk_req_q, .walk_addr_q, .walk_ack, .walk_err, .walk_rdata,
		.mem_start_q, .ext_addr_q, .mem_done, .mem_err,
		.mem_linefetch(lf), .cp_wr, .cp_rd, .cp_reg, .cp_wdata,
		.cp_rdata_q, .tlb_flush_q, .tlb_purge_q, .purge_addr_q);
	pwfu_mem_model mem (.core_clk, .rst_b, .walk_req_q, .walk_ack,
		.walk_err, .walk_rdata, .mem_start_q, .mem_done, .mem_err, .entry,
		.lat, .walk_fail, .mem_fail);

	// ---------------------------------------------------------------
	// Shared tasks
	// ---------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] e, g);
		n_compared++;
		if (g !== e) begin
			num_errors++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic cpw(input logic [3:0] r, input logic [31:0] d);
		@(posedge core_clk);
		cp_wr <= 1'h1;
		cp_reg <= r;
		cp_wdata <= d;
		@(posedge core_clk);
		cp_wr <= 1'h0;
	endtask
	task automatic cpr(input logic [3:0] r);
		@(posedge core_clk);
		cp_rd <= 1'h1;
		cp_reg <= r;
		@(posedge core_clk);
		cp_rd <= 1'h0;
		@(negedge core_clk);
		rd = cp_rdata_q;
	endtask
	task automatic set_ent(input logic [31:0] e, input logic [1:0] l,
		input logic wf, mf);
		@(posedge core_clk);
		entry <= e;
		lat <= l;
		walk_fail <= wf;
		mem_fail <= mf;
	endtask
	// Word read in supervisor mode; results land in ab, tg, pa and cbits.
	task automatic acc(input logic [31:0] va, l1, input logic d, le);
		int n;
		@(negedge core_clk);
		while (req_ready_q !== 1'h1) @(negedge core_clk);
		@(posedge core_clk);
		req_valid <= 1'h1;
		req <= {va, l1, le, d, 1'h1, 1'h0, 1'h0};
		@(posedge core_clk);
		req_valid <= 1'h0;
		n = 0;
		do begin
			@(negedge core_clk);
			n++;
		end while (rsp_q.valid !== 1'h1 && n < 60);
		if (n >= 60) chk("answer", 32'h1, 32'h0);
		ab = rsp_q.abort;
		tg = rsp_q.iabort_tag;
		pa = rsp_q.pa;
		cbits = {rsp_q.cacheable, rsp_q.bufferable};
	endtask
	task automatic fchk(input logic [7:0] fs, input logic [31:0] va);
		cpr(`PWFU_REG_STATUS);
		chk("fault_status", {24'h0, fs}, rd);
		cpr(`PWFU_REG_ADDR);
		chk("fault_address", va, rd);
	endtask

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task automatic t_regs;
		cpr(`PWFU_REG_STATUS);
		chk("status reset", `PWFU_FSR_RST, rd);
		cpw(`PWFU_REG_DOMAIN, 32'hA5C33C5A);
		cpr(`PWFU_REG_DOMAIN);
		chk("domain reg", 32'hA5C33C5A, rd);
		cpr(4'h4);
		chk("unmapped", 32'h0, rd);
		// A write to the address number purges instead of storing.
		cpw(`PWFU_REG_ADDR, 32'h1234C000);
		@(negedge core_clk);
		chk("purge", 32'h1, {31'h0, tlb_purge_q});
		chk("purge addr", 32'h1234C000, purge_addr_q);
	endtask
	// Fast bus is on so that an aborted access may still move the address.
	task automatic t_align;
		@(posedge core_clk);
		fastbus <= 1'h1;
		acc(32'h00045679, 32'h0, 1'h1, 1'h0);
		chk("abort", 32'h1, {31'h0, ab});
		chk("fast addr", 32'h00045679, ext_addr_q);
		fchk({4'h0, `PWFU_FC_ALIGN}, 32'h00045679);
		acc(32'h00045678, 32'h0, 1'h1, 1'h1);
		fchk({4'h0, `PWFU_FC_WALK_L1}, 32'h00045678);
		acc(32'h00045678, 32'h000001E0, 1'h1, 1'h0);
		fchk({4'hF, `PWFU_FC_TRANS_SEC}, 32'h00045678);
	endtask
	// Section in domain 2 with no-access bits: each domain value in turn.
	task automatic t_domain;
		logic [3:0] ec[4] = '{`PWFU_FC_DOM_SEC, `PWFU_FC_PERM_SEC,
			`PWFU_FC_DOM_SEC, 4'h0};
		for (int v = 0; v < 4; v++) begin
			cpw(`PWFU_REG_DOMAIN, 32'(v) << 4);
			acc(32'h00045678, 32'h1230005E, 1'h1, 1'h0);
			chk("abort", {31'h0, v != 3}, {31'h0, ab});
			if (v != 3) begin
				fchk({4'h2, ec[v]}, 32'h00045678);
			end else begin
				chk("section pa", 32'h12345678, pa);
			end
		end
	endtask
	task automatic t_page;
		cpw(`PWFU_REG_DOMAIN, 32'h00000004);
		set_ent(32'hABCDEC0A, 2'h0, 1'h0, 1'h0);
		acc(32'h00045C34, 32'h00040031, 1'h1, 1'h0);
		chk("small pa", 32'hABCDEC34, pa);
		chk("small cb", 32'h2, {30'h0, cbits});
		acc(32'h00045034, 32'h00040031, 1'h1, 1'h0);
		fchk({4'h1, `PWFU_FC_PERM_PAGE}, 32'h00045034);
		set_ent(32'h5A5A0305, 2'h3, 1'h0, 1'h0);
		acc(32'h00049ABC, 32'h00040031, 1'h1, 1'h0);
		chk("large pa", 32'h5A5A9ABC, pa);
		chk("large cb", 32'h1, {30'h0, cbits});
		acc(32'h0004DABC, 32'h00040031, 1'h1, 1'h0);
		fchk({4'h1, `PWFU_FC_PERM_PAGE}, 32'h0004DABC);
		for (int i = 0; i < 2; i++) begin
			set_ent(i ? 32'hABCDEC0B : 32'hABCDEC08, 2'h1, 1'h0, 1'h0);
			acc(32'h00045C34, 32'h00040031, 1'h1, 1'h0);
			fchk({4'h1, `PWFU_FC_TRANS_PAGE}, 32'h00045C34);
		end
		set_ent(32'hABCDEC0A, 2'h0, 1'h1, 1'h0);
		acc(32'h00045C30, 32'h00040031, 1'h1, 1'h0);
		fchk({4'h1, `PWFU_FC_WALK_L2}, 32'h00045C30);
		set_ent(32'hABCDEC0A, 2'h0, 1'h0, 1'h0);
		cpw(`PWFU_REG_DOMAIN, 32'h0);
		acc(32'h00045C38, 32'h00040031, 1'h1, 1'h0);
		fchk({4'h1, `PWFU_FC_DOM_PAGE}, 32'h00045C38);
	endtask
	// A bus error leaves status that an instruction abort must not touch.
	task automatic t_bus;
		cpw(`PWFU_REG_DOMAIN, 32'h00000030);
		set_ent(32'h0, 2'h2, 1'h0, 1'h1);
		acc(32'h00081000, 32'h1230005E, 1'h1, 1'h0);
		chk("ext addr", 32'h12381000, ext_addr_q);
		fchk({4'h2, `PWFU_FC_BUS_SEC}, 32'h00081000);
		acc(32'h00090000, 32'h000001E0, 1'h0, 1'h0);
		chk("iabort", 32'h3, {30'h0, ab, tg});
		fchk({4'h2, `PWFU_FC_BUS_SEC}, 32'h00081000);
		// Line fetch errors, section then page, both in manager domains.
		cpw(`PWFU_REG_DOMAIN, 32'h0000003C);
		@(posedge core_clk);
		lf <= 1'h1;
		acc(32'h00082000, 32'h1230005E, 1'h1, 1'h0);
		fchk({4'h2, `PWFU_FC_LINE_SEC}, 32'h00082000);
		set_ent(32'hABCDEC0A, 2'h0, 1'h0, 1'h1);
		acc(32'h00045C3C, 32'h00040031, 1'h1, 1'h0);
		fchk({4'h1, `PWFU_FC_LINE_PAGE}, 32'h00045C3C);
		// A flush write pulses but leaves the recorded fault in place.
		cpw(`PWFU_REG_STATUS, 32'h0);
		@(negedge core_clk);
		chk("flush", 32'h1, {31'h0, tlb_flush_q});
		fchk({4'h1, `PWFU_FC_LINE_PAGE}, 32'h00045C3C);
	endtask
	task automatic stop_test;
		$display("compared %0d errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// ---------------------------------------------------------------
	// Main sequence and watchdog
	// ---------------------------------------------------------------
	initial begin
		repeat (3) @(posedge core_clk);
		rst_b <= 1'h1;
		t_regs;
		t_align;
		t_domain;
		t_page;
		t_bus;
		stop_test;
	end
	// The scenarios need a few hundred cycles; this allows 20000.
	initial begin
		#200000;
		num_errors++;
		stop_test;
	end
endmodule
